//--- rtl/csm_pkg.sv
// package of constants for the can sleep mode control block
package csm_pkg;
  localparam int NUM_TX = 3;
  localparam logic [11:0] ADDR_CTL0 = 12'h000;
  localparam logic [11:0] ADDR_TXE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [11:0] ADDR_RX_DATA = 12'h014;
  localparam logic [11:0] ADDR_ABORT = 12'h018;
  localparam int CTL0_SLEEP_REQ_BIT = 1;
  localparam int CTL0_SLEEP_ACK_BIT = 0;
  localparam int ST_BUSOFF_BIT = 0;
  localparam int ST_TX_ACTIVE_BIT = 1;
  localparam int ST_RX_ACTIVE_BIT = 2;
  localparam int ST_RX_FULL_BIT = 3;
  localparam int ST_CLK_EN_BIT = 4;
  localparam int IRQ_SLEEP_ENTER_BIT = 0;
  localparam int IRQ_SLEEP_EXIT_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  localparam logic [3:0] SYNC_DELAY = 4'h4;
  localparam logic [3:0] WAKE_DELAY = 4'h2;
  localparam int IDLE_BITS = 11;
  localparam logic [7:0] BUSOFF_SEQ = 8'h80;
  localparam int BIT_DIV = 20;
  localparam int RX_DEPTH = 4;
  localparam int RX_AW = 2;
  localparam int RX_DW = 32;
endpackage : csm_pkg

//--- rtl/csm_rx_if.sv
// interface between controller and receive fifo memory
`timescale 1ns/10ps
`default_nettype none
interface csm_rx_if;
  logic wrEn;
  logic [csm_pkg::RX_AW-1:0] wrAddr;
  logic [csm_pkg::RX_DW-1:0] wrData;
  logic [csm_pkg::RX_AW-1:0] rdAddr;
  logic [csm_pkg::RX_DW-1:0] rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : csm_rx_if
`default_nettype wire

//--- rtl/csm_rx_mem.sv
// receive fifo storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module csm_rx_mem (
  input wire logic core_clk,
  csm_rx_if.mem port
);
  logic [csm_pkg::RX_DW-1:0] store [csm_pkg::RX_DEPTH];
  always_ff @(posedge core_clk) begin
    if (port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
    port.rdData <= store[port.rdAddr];
  end
endmodule // csm_rx_mem
`default_nettype wire

//--- rtl/csm_sleep_ctrl.sv
// sleep mode control of a can controller with apb registers
// Behaviour
// - only the sleep request bit in control register 0 triggers sleep
// - sleep entry waits a fixed sync delay plus current tx/rx activity
// - pending transmit buffers are not aborted; sleep waits until all are empty (buffer 0 by tx_done, any by software abort)
// - an ongoing reception finishes; sleep at the next bus idle
// - no activity: sleep enters directly, no bus event awaited
// - while asleep both request and acknowledge read set
// - asleep: protocol clock enable off, register access keeps running
// - bus-off recovery count of 128 times 11 recessive bits halts asleep
// - transmit pin held recessive during sleep
// - received-full message readable and flag clearable during sleep
// - no shift from receive fifo into foreground buffer while asleep
// - transmit buffers writable asleep, no transmission started by it
// - no transmit abort carried out while asleep
`timescale 1ns/10ps
`default_nettype none
module csm_sleep_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx_pin,
  output logic can_tx_pin,
  input wire logic tx_done,
  input wire logic tx_bit,
  input wire logic rx_frame_done,
  input wire logic [31:0] rx_frame_data,
  input wire logic bus_off_in,
  output logic protocol_clk_en,
  output logic irq
);
  // ----------------------------------------
  // types and declarations
  // ----------------------------------------
  typedef enum logic [2:0] {ST_AWAKE, ST_SYNC, ST_DRAIN, ST_ASLEEP, ST_WAKE} csm_state_e;
  csm_state_e state, next_state;
  logic [3:0] delayCnt;
  logic sleepReq;
  logic [csm_pkg::NUM_TX-1:0] txEmpty;
  logic [csm_pkg::NUM_TX-1:0] abortReq;
  logic rxFull;
  logic [31:0] rxForeground;
  logic [csm_pkg::IRQ_WIDTH-1:0] irqStat, irqMask;
  logic rxSync1, rxSync2;
  logic [4:0] divCnt;
  logic bitTick;
  logic [3:0] recessiveCnt;
  logic [7:0] busOffCnt;
  logic rxActive;
  logic [csm_pkg::RX_AW:0] fifoWr, fifoRd;
  logic fifoLoadPend;
  csm_rx_if rxIf();

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction
  wire logic wrAcc = psel && penable && pwrite;
  wire logic rdAcc = psel && penable && !pwrite;
  wire logic wrCtl0 = wrAcc && hit(paddr, csm_pkg::ADDR_CTL0);
  wire logic wrTxe = wrAcc && hit(paddr, csm_pkg::ADDR_TXE);
  wire logic wrMask = wrAcc && hit(paddr, csm_pkg::ADDR_IRQ_MASK);
  wire logic wrAbort = wrAcc && hit(paddr, csm_pkg::ADDR_ABORT);
  wire logic wrStatus = wrAcc && hit(paddr, csm_pkg::ADDR_STATUS);
  wire logic rdIrq = rdAcc && hit(paddr, csm_pkg::ADDR_IRQ_STAT);
  wire logic mapped = hit(paddr, csm_pkg::ADDR_CTL0) || hit(paddr, csm_pkg::ADDR_TXE)
    || hit(paddr, csm_pkg::ADDR_STATUS) || hit(paddr, csm_pkg::ADDR_IRQ_STAT)
    || hit(paddr, csm_pkg::ADDR_IRQ_MASK) || hit(paddr, csm_pkg::ADDR_RX_DATA)
    || hit(paddr, csm_pkg::ADDR_ABORT);
  wire logic asleep = state == ST_ASLEEP;
  wire logic sleepAck = asleep || state == ST_WAKE;
  wire logic clkOn = !(asleep || state == ST_WAKE && delayCnt != 4'h0);
  wire logic txPending = !(&txEmpty);
  wire logic busIdle = !rxActive;
  wire logic fifoEmpty = fifoWr == fifoRd;
  wire logic fifoFull = fifoWr == {!fifoRd[csm_pkg::RX_AW], fifoRd[csm_pkg::RX_AW-1:0]};

  // ----------------------------------------
  // sleep state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_AWAKE: begin
        if (sleepReq) begin
          next_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (!sleepReq) begin
          next_state = ST_AWAKE;
        end else if (delayCnt == 4'h0) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!sleepReq) begin
          next_state = ST_AWAKE;
        end else if (!txPending && busIdle) begin
          next_state = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (!sleepReq) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (delayCnt == 4'h0) begin
          next_state = ST_AWAKE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_AWAKE;
      delayCnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state == ST_AWAKE && next_state == ST_SYNC) begin
        delayCnt <= csm_pkg::SYNC_DELAY;
      end else if (state == ST_ASLEEP && next_state == ST_WAKE) begin
        delayCnt <= csm_pkg::WAKE_DELAY;
      end else if (delayCnt != 4'h0) begin
        delayCnt <= delayCnt - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // control, transmit and interrupt registers
  // ----------------------------------------
  wire logic enterEv = state == ST_DRAIN && next_state == ST_ASLEEP;
  wire logic exitEv = state == ST_WAKE && next_state == ST_AWAKE;
  wire logic [csm_pkg::IRQ_WIDTH-1:0] irqSet = {exitEv, enterEv};
  // a read clears only the bits it captured, later events survive
  wire logic [csm_pkg::IRQ_WIDTH-1:0] irqKeep =
    rdIrq ? irqStat & ~prdata[csm_pkg::IRQ_WIDTH-1:0] : irqStat;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sleepReq <= 1'b0;
      irqMask <= '0;
      irqStat <= '0;
    end else begin
      if (wrCtl0) begin
        sleepReq <= pwdata[csm_pkg::CTL0_SLEEP_REQ_BIT];
      end
      if (wrMask) begin
        irqMask <= pwdata[csm_pkg::IRQ_WIDTH-1:0];
      end
      irqStat <= irqKeep | irqSet;
    end
  end
  assign irq = |(irqStat & irqMask);

  genvar g;
  generate
    for (g = 0; g < csm_pkg::NUM_TX; g++) begin : gTx
      wire logic sentHere = tx_done && !asleep && txPending && g == 0;
      wire logic abortHere = abortReq[g] && !asleep;
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          txEmpty[g] <= 1'b1;
          abortReq[g] <= 1'b0;
        end else begin
          // cleared by software, also asleep
          if (sentHere || abortHere) begin
            txEmpty[g] <= 1'b1;
          end else if (wrTxe && pwdata[g]) begin
            txEmpty[g] <= 1'b0;
          end
          if (abortHere) begin
            abortReq[g] <= 1'b0;
          end else if (wrAbort && pwdata[g]) begin
            abortReq[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // bus pins and bus-off counting
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxSync1 <= 1'b1;
      rxSync2 <= 1'b1;
      can_tx_pin <= 1'b1;
      divCnt <= 5'h0;
      recessiveCnt <= 4'h0;
      busOffCnt <= 8'h0;
      rxActive <= 1'b0;
    end else begin
      rxSync1 <= can_rx_pin;
      rxSync2 <= rxSync1;
      can_tx_pin <= (clkOn && txPending) ? tx_bit : 1'b1;
      if (clkOn) begin
        divCnt <= (divCnt == 5'(csm_pkg::BIT_DIV - 1)) ? 5'h0 : divCnt + 5'h1;
      end
      if (bitTick) begin
        if (!rxSync2) begin
          recessiveCnt <= 4'h0;
          rxActive <= 1'b1;
        end else if (recessiveCnt == 4'(csm_pkg::IDLE_BITS - 1)) begin
          recessiveCnt <= 4'h0;
          rxActive <= 1'b0;
          if (bus_off_in && busOffCnt != csm_pkg::BUSOFF_SEQ) begin
            busOffCnt <= busOffCnt + 8'h1;
          end
        end else begin
          recessiveCnt <= recessiveCnt + 4'h1;
        end
      end
      if (!bus_off_in) begin
        busOffCnt <= 8'h0;
      end
    end
  end
  assign bitTick = clkOn && divCnt == 5'(csm_pkg::BIT_DIV - 1);
  assign protocol_clk_en = clkOn;

  // ----------------------------------------
  // receive fifo and foreground buffer
  // ----------------------------------------
  wire logic fifoPush = rx_frame_done && clkOn && !fifoFull;
  wire logic fgLoad = !rxFull && !fifoEmpty && !asleep && !fifoLoadPend;
  wire logic rxClear = wrStatus && pwdata[csm_pkg::ST_RX_FULL_BIT];
  // pointer step, sized to the wrap bit
  wire logic [csm_pkg::RX_AW:0] ptrStep = {{csm_pkg::RX_AW{1'b0}}, 1'b1};
  assign rxIf.wrEn = fifoPush;
  assign rxIf.wrAddr = fifoWr[csm_pkg::RX_AW-1:0];
  assign rxIf.wrData = rx_frame_data;
  assign rxIf.rdAddr = fifoRd[csm_pkg::RX_AW-1:0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fifoWr <= '0;
      fifoRd <= '0;
      fifoLoadPend <= 1'b0;
      rxFull <= 1'b0;
      rxForeground <= 32'h0;
    end else begin
      if (fifoPush) begin
        fifoWr <= fifoWr + ptrStep;
      end
      fifoLoadPend <= fgLoad;
      // a load that meets sleep entry is dropped and retried on wake
      if (fifoLoadPend && !asleep) begin
        rxForeground <= rxIf.rdData;
        fifoRd <= fifoRd + ptrStep;
        rxFull <= 1'b1;
      end else if (rxClear) begin
        rxFull <= 1'b0;
      end
    end
  end

  csm_rx_mem uMem (
    .core_clk(core_clk),
    .port(rxIf.mem)
  );

  // ----------------------------------------
  // apb read path
  // ----------------------------------------
  wire logic [31:0] ctlWord = 32'({sleepReq, sleepAck});
  wire logic [31:0] statWord = 32'({clkOn, rxFull, rxActive, txPending, busOffCnt == csm_pkg::BUSOFF_SEQ});
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit(paddr, csm_pkg::ADDR_CTL0) ? ctlWord :
        hit(paddr, csm_pkg::ADDR_TXE) ? 32'(txEmpty) :
        hit(paddr, csm_pkg::ADDR_STATUS) ? statWord :
        hit(paddr, csm_pkg::ADDR_IRQ_STAT) ? 32'(irqStat) :
        hit(paddr, csm_pkg::ADDR_IRQ_MASK) ? 32'(irqMask) :
        hit(paddr, csm_pkg::ADDR_RX_DATA) ? rxForeground :
        hit(paddr, csm_pkg::ADDR_ABORT) ? 32'(abortReq) : 32'h0;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
endmodule // csm_sleep_ctrl
`default_nettype wire

//--- bench/csm_sleep_ctrl_assertions.sv
// checker of sleep control port behaviour
`timescale 1ns/10ps
`default_nettype none
module csm_sleep_ctrl_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic can_tx_pin,
  input wire logic tx_bit,
  input wire logic protocol_clk_en
);
  // ----
  // helpers
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic acc;
  logic mapped;
  logic ctlWr;
  logic reqBit;
  logic reqSeen;
  assign acc = psel && penable;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= csm_pkg::ADDR_ABORT;
  assign ctlWr = acc && pwrite && paddr == csm_pkg::ADDR_CTL0;
  assign reqBit = pwdata[csm_pkg::CTL0_SLEEP_REQ_BIT];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) reqSeen <= 1'b0;
    else if (ctlWr) reqSeen <= reqBit;
  end
  sequence s_req; ctlWr && reqBit && protocol_clk_en; endsequence
  sequence s_clr; ctlWr && !reqBit && !protocol_clk_en; endsequence
  // ----
  // properties
  // ----
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_unmapped; acc && !mapped |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
  property p_mapped; acc && mapped |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("error on mapped access");
  property p_tx_rec; $fell(protocol_clk_en) |-> can_tx_pin; endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("sleep entered with tx active");
  property p_tx_hold; !protocol_clk_en && !tx_bit |=> can_tx_pin; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx pin dominant asleep");
  property p_sync; s_req |=> protocol_clk_en [*4]; endproperty
  a_sync: assert property (p_sync) else $error("sleep before sync delay");
  property p_wake; s_clr |=> !protocol_clk_en [*2] ##[1:3] protocol_clk_en; endproperty
  a_wake: assert property (p_wake) else $error("clock not restarted on wake");
  property p_trigger; $fell(protocol_clk_en) |-> reqSeen; endproperty
  a_trigger: assert property (p_trigger) else $error("sleep without request");
endmodule // csm_sleep_ctrl_assertions
bind csm_sleep_ctrl csm_sleep_ctrl_assertions csm_sleep_ctrl_assertions_inst (.core_clk, .rstn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .can_tx_pin, .tx_bit,
  .protocol_clk_en);
`default_nettype wire

//--- bench/csm_bus_node.sv
// model of other nodes on the can bus
`timescale 1ns/10ps
`default_nettype none
module csm_bus_node (
  input wire logic core_clk,
  output logic canRx,
  output logic frameDone,
  output logic [31:0] frameData
);
  // ----
  // frame driver
  // ----
  initial begin
    canRx = 1'b1;
    frameDone = 1'b0;
    frameData = 32'h0;
  end
  // alternating bits, then idle recessive and a receive pulse
  task automatic send_frame(input int nbits, input logic [31:0] d);
    for (int i = 0; i < nbits; i++) begin
      canRx <= i[0];
      repeat (csm_pkg::BIT_DIV) @(posedge core_clk);
    end
    canRx <= 1'b1;
    frameDone <= 1'b1;
    frameData <= d;
    @(posedge core_clk);
    frameDone <= 1'b0;
    frameData <= ~d;
  endtask
endmodule // csm_bus_node
`default_nettype wire

//--- bench/test_can_sleep_mode_control.sv
// testbench of the can sleep mode control block
`timescale 1ns/10ps
`default_nettype none
module test_can_sleep_mode_control;
  // ----
  // setup
  // ----
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, frameData, q;
  logic pready, pslverr, canRx, canTx, frameDone, clkEn, irq;
  logic txDone = 1'b0, txBit = 1'b1, busOff = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  always #2.5 core_clk = ~core_clk;
  csm_sleep_ctrl csm_sleep_ctrl_inst (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .can_rx_pin(canRx), .can_tx_pin(canTx),
    .tx_done(txDone), .tx_bit(txBit), .rx_frame_done(frameDone), .rx_frame_data(frameData),
    .bus_off_in(busOff), .protocol_clk_en(clkEn), .irq);
  csm_bus_node csm_bus_node_inst (.core_clk, .canRx, .frameDone, .frameData);
  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input logic v, input int lim);
    n = 0;
    do begin
      apb(1'b0, csm_pkg::ADDR_CTL0, 32'h0);
      n++;
    end while (q[0] !== v && n < lim);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      close_out();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (250) @(posedge core_clk);
    apb(1'b0, csm_pkg::ADDR_CTL0, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    check(q, 32'h0);
    csm_bus_node_inst.send_frame(4, 32'h0000a5a5);
    csm_bus_node_inst.send_frame(4, 32'h00003c3c);
    repeat (300) @(posedge core_clk);
    apb(1'b1, csm_pkg::ADDR_IRQ_MASK, 32'h3);
    busOff <= 1'b1;
    apb(1'b1, csm_pkg::ADDR_CTL0, 32'h2);
    poll(1'b1, 4);
    check(q & 32'h3, 32'h3);
    check({31'h0, clkEn}, 32'h0);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, csm_pkg::ADDR_IRQ_STAT, 32'h0);
    check(q, 32'h1);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    fork
      csm_bus_node_inst.send_frame(4, 32'h00005a5a);
    join_none
    repeat (100) @(posedge core_clk);
    apb(1'b0, csm_pkg::ADDR_RX_DATA, 32'h0);
    check(q, 32'h0000a5a5);
    apb(1'b0, csm_pkg::ADDR_STATUS, 32'h0);
    check(q & 32'h8, 32'h8);
    apb(1'b1, csm_pkg::ADDR_STATUS, 32'h8);
    apb(1'b0, csm_pkg::ADDR_STATUS, 32'h0);
    check(q & 32'h8, 32'h0);
    apb(1'b0, csm_pkg::ADDR_RX_DATA, 32'h0);
    check(q, 32'h0000a5a5);
    txBit <= 1'b0;
    apb(1'b1, csm_pkg::ADDR_TXE, 32'h1);
    apb(1'b1, csm_pkg::ADDR_ABORT, 32'h1);
    repeat (20) @(posedge core_clk);
    check({31'h0, canTx}, 32'h1);
    apb(1'b0, csm_pkg::ADDR_TXE, 32'h0);
    check(q & 32'h7, 32'h6);
    repeat (30000) @(posedge core_clk);
    apb(1'b0, csm_pkg::ADDR_STATUS, 32'h0);
    check(q & 32'h1, 32'h0);
    apb(1'b1, csm_pkg::ADDR_CTL0, 32'h0);
    poll(1'b0, 10);
    check(q & 32'h3, 32'h0);
    check({31'h0, clkEn}, 32'h1);
    apb(1'b0, csm_pkg::ADDR_IRQ_STAT, 32'h0);
    check(q, 32'h2);
    apb(1'b0, csm_pkg::ADDR_TXE, 32'h0);
    check(q & 32'h7, 32'h7);
    apb(1'b0, csm_pkg::ADDR_RX_DATA, 32'h0);
    check(q, 32'h00003c3c);
    repeat (29000) @(posedge core_clk);
    apb(1'b0, csm_pkg::ADDR_STATUS, 32'h0);
    check(q & 32'h1, 32'h1);
    busOff <= 1'b0;
    apb(1'b1, csm_pkg::ADDR_TXE, 32'h1);
    repeat (8) @(posedge core_clk);
    apb(1'b1, csm_pkg::ADDR_CTL0, 32'h2);
    repeat (60) @(posedge core_clk);
    check({31'h0, canTx}, 32'h0);
    apb(1'b0, csm_pkg::ADDR_CTL0, 32'h0);
    check(q & 32'h3, 32'h2);
    txDone <= 1'b1;
    @(posedge core_clk);
    txDone <= 1'b0;
    poll(1'b1, 10);
    check(q & 32'h3, 32'h3);
    apb(1'b1, csm_pkg::ADDR_CTL0, 32'h0);
    poll(1'b0, 10);
    fork
      csm_bus_node_inst.send_frame(12, 32'h0000c3c3);
    join_none
    repeat (40) @(posedge core_clk);
    apb(1'b1, csm_pkg::ADDR_CTL0, 32'h2);
    repeat (100) @(posedge core_clk);
    apb(1'b0, csm_pkg::ADDR_CTL0, 32'h0);
    check(q & 32'h3, 32'h2);
    poll(1'b1, 300);
    check(q & 32'h3, 32'h3);
    check({31'h0, 1'(n > 60)}, 32'h1);
    close_out();
  end
endmodule // test_can_sleep_mode_control
`default_nettype wire
